/* hw/tmr8_pkg.sv */
// package of constants and carriers for the dual 8-bit timer block
// What this block does
// - event mode counts count pin falling edges
// - event match raises irq, clears counter
// - compare value unbuffered in event/divider modes
// - divider mode gives square wave on pin
// - divider match toggles flop, clears, raises irq
// - divider pin is inverse flop; reset clears
// - stop holds pin; init change only later
// - bit3 runs, bit7 presets flop
// - pwm duty match toggles flop, keeps counting
// - pwm overflow toggles, clears, raises irq
// - pwm pin inverse flop, either polarity
// - duty double buffered, loads on irq
// - running duty read returns active stage
// - pwm stop holds pin; init later
package tmr8_pkg;
    // control register field positions
    localparam int CTL_MODE_LSB = 0;
    localparam int CTL_RUN_BIT = 3;
    localparam int CTL_SRC_LSB = 4;
    localparam int CTL_FF_BIT = 7;
    localparam logic [7:0] CTL_RESET = 8'h00;
    localparam logic [7:0] CMP_RESET = 8'h00;
    localparam logic [7:0] DUTY_RESET = 8'h00;
    localparam logic [7:0] CNT_MAX = 8'hFF;
    localparam int CHANNELS = 2;
    // prescaler divide ratios, as powers of two of the system clock
    localparam int DIV_P11 = 11;
    localparam int DIV_P7 = 7;
    localparam int DIV_P5 = 5;
    localparam int DIV_P3 = 3;
    localparam int DIV_P1 = 1;
    localparam int SUB_P3 = 3;
    localparam int PRE_BITS = 12;

    // modes, gray coded
    typedef enum logic [1:0] {
        TMR8_EVENT = 2'b00,
        TMR8_DIVIDER = 2'b01,
        TMR8_PWM = 2'b11,
        TMR8_IDLE = 2'b10
    } tmr8_mode_t;

    // source selections
    typedef enum logic [2:0] {
        TMR8_SRC_SLOW = 3'h0,
        TMR8_SRC_D7 = 3'h1,
        TMR8_SRC_D5 = 3'h2,
        TMR8_SRC_D3 = 3'h3,
        TMR8_SRC_SUB = 3'h4,
        TMR8_SRC_HALF = 3'h5,
        TMR8_SRC_FULL = 3'h6,
        TMR8_SRC_RSV = 3'h7
    } tmr8_src_t;

    // cpu write port to one channel
    typedef struct packed {
        logic ctlWr;
        logic cmpWr;
        logic dutyWr;
        logic [7:0] data;
    } tmr8_wr_t;

    // per-channel status and pins
    typedef struct packed {
        logic [7:0] ctl;
        logic [7:0] cmp;
        logic [7:0] dutyRd;
        logic [7:0] count;
        logic matchIrq;
        logic dividerOutPin;
        logic pwmOutPin;
    } tmr8_stat_t;
endpackage

/* hw/tmr8_channel.sv */
// one 8-bit timer/counter channel
`timescale 1ns/1ps
module tmr8_channel (
    input wire logic clk_sys,
    input wire logic rst,
    input wire tmr8_pkg::tmr8_wr_t wr,
    input wire logic [tmr8_pkg::PRE_BITS-1:0] tapPulse,
    input wire logic subTick,
    input wire logic subSlowTick,
    input wire logic prescalerTapSelect,
    input wire logic countInputPin,
    output tmr8_pkg::tmr8_stat_t stat
);
    import tmr8_pkg::*;

    logic [7:0] ctl_q; // channel_control_reg
    logic [7:0] cmp_q; // compare_value_reg, no shadow
    logic [7:0] dutyBuf_q; // written duty, held
    logic [7:0] dutyAct_q; // active compare stage
    logic [7:0] cnt_q; // up-counter
    logic ff_q; // timer flip-flop
    logic pinPrev_q; // last count pin level
    logic irq_q; // match pulse
    logic tick; // count enable this cycle
    logic run;
    logic match;
    tmr8_mode_t mode;
    tmr8_src_t src;

    assign run = ctl_q[CTL_RUN_BIT];
    assign mode = tmr8_mode_t'(ctl_q[CTL_MODE_LSB +: 2]);
    assign src = tmr8_src_t'(ctl_q[CTL_SRC_LSB +: 3]);

    // tick source: edge for events, prescaler tap, sub clock, every clock on the full source, none on reserved
    always_comb begin
        case (src)
            TMR8_SRC_SLOW: tick = prescalerTapSelect ? subSlowTick : tapPulse[DIV_P11];
            TMR8_SRC_D7: tick = tapPulse[DIV_P7];
            TMR8_SRC_D5: tick = tapPulse[DIV_P5];
            TMR8_SRC_D3: tick = tapPulse[DIV_P3];
            TMR8_SRC_SUB: tick = subTick;
            TMR8_SRC_HALF: tick = tapPulse[DIV_P1];
            TMR8_SRC_FULL: tick = 1'b1;
            default: tick = 1'b0;
        endcase
        if (mode == TMR8_EVENT) begin
            tick = pinPrev_q & ~countInputPin;
        end
        if (!run || mode == TMR8_IDLE) begin
            tick = 1'b0;
        end
    end

    // compare against live register, or overflow at CNT_MAX in pwm
    always_comb begin
        match = 1'b0;
        if (tick) begin
            case (mode)
                TMR8_EVENT: match = (cnt_q == cmp_q);
                TMR8_DIVIDER: match = (cnt_q == cmp_q);
                TMR8_PWM: match = (cnt_q == CNT_MAX);
                default: match = 1'b0;
            endcase
        end
    end

    // control register write
    always_ff @(posedge clk_sys) begin
        if (rst) ctl_q <= CTL_RESET;
        else if (wr.ctlWr) ctl_q <= wr.data;
    end

    // compare register write, takes effect at once
    always_ff @(posedge clk_sys) begin
        if (rst) cmp_q <= CMP_RESET;
        else if (wr.cmpWr) cmp_q <= wr.data;
    end

    // count pin history for falling-edge detect
    always_ff @(posedge clk_sys) begin
        if (rst) pinPrev_q <= 1'b1;
        else pinPrev_q <= countInputPin;
    end

    // up-counter: clear on match, wrap handled by overflow in pwm
    always_ff @(posedge clk_sys) begin
        if (rst) cnt_q <= 8'h00;
        else if (!run) cnt_q <= 8'h00;
        else if (match) cnt_q <= 8'h00;
        else if (tick) cnt_q <= cnt_q + 8'h01;
    end

    // duty double buffer; stopped writes pass straight through
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            dutyBuf_q <= DUTY_RESET;
            dutyAct_q <= DUTY_RESET;
        end else begin
            if (wr.dutyWr) dutyBuf_q <= wr.data;
            // a write in the irq cycle loses; old buffer loads
            if (match && mode == TMR8_PWM) dutyAct_q <= dutyBuf_q;
            else if (wr.dutyWr && !run) dutyAct_q <= wr.data;
        end
    end

    // timer flip-flop; preset only when stopped so a stop holds the pin
    always_ff @(posedge clk_sys) begin
        if (rst) ff_q <= 1'b0;
        else if (wr.ctlWr && !run && !wr.data[CTL_RUN_BIT]) ff_q <= wr.data[CTL_FF_BIT];
        else if (wr.ctlWr && !run) ff_q <= wr.data[CTL_FF_BIT];
        else if (tick && mode == TMR8_DIVIDER && match) ff_q <= ~ff_q;
        else if (tick && mode == TMR8_PWM && (match || cnt_q == dutyAct_q)) ff_q <= ~ff_q;
    end

    // one-cycle interrupt pulse from every clearing match
    always_ff @(posedge clk_sys) begin
        if (rst) irq_q <= 1'b0;
        else irq_q <= match;
    end

    // status; duty read shows the active stage while pwm runs
    always_comb begin
        stat.ctl = ctl_q;
        stat.cmp = cmp_q;
        stat.dutyRd = (run && mode == TMR8_PWM) ? dutyAct_q : dutyBuf_q;
        stat.count = cnt_q;
        stat.matchIrq = irq_q;
        stat.dividerOutPin = ~ff_q;
        stat.pwmOutPin = ~ff_q;
    end
endmodule // tmr8_channel

/* hw/tmr8_top.sv */
// dual 8-bit timer/counter with shared prescaler
`timescale 1ns/1ps
module tmr8_top (
    input wire logic clk_sys,
    input wire logic rst,
    input wire tmr8_pkg::tmr8_wr_t wr0,
    input wire tmr8_pkg::tmr8_wr_t wr1,
    input wire logic subClkTick,
    input wire logic prescalerTapSelect,
    input wire logic countInputPin0,
    input wire logic countInputPin1,
    output tmr8_pkg::tmr8_stat_t stat0,
    output tmr8_pkg::tmr8_stat_t stat1
);
    import tmr8_pkg::*;

    logic [PRE_BITS-1:0] pre_q; // free-running prescaler
    logic [PRE_BITS-1:0] tapPulse; // one-cycle enable per tap
    logic [2:0] sub_q; // sub clock divider
    logic subSlowTick;

    // prescaler counts every system clock
    always_ff @(posedge clk_sys) begin
        if (rst) pre_q <= '0;
        else pre_q <= pre_q + {{(PRE_BITS-1){1'b0}}, 1'b1};
    end

    // sub clock divided by eight for the slow tap
    always_ff @(posedge clk_sys) begin
        if (rst) sub_q <= 3'h0;
        else if (subClkTick) sub_q <= sub_q + 3'h1;
    end

    assign subSlowTick = subClkTick && (sub_q == 3'h7);

    // tap k pulses once every 2^k cycles: all prescaler bits below k are set
    // a running and keeps the part-selects constant, so tap 0 is every clock
    always_comb begin
        logic lowOnes; // and of the prescaler bits below the current tap
        lowOnes = 1'b1;
        for (int k = 0; k < PRE_BITS; k++) begin
            tapPulse[k] = lowOnes;
            lowOnes = lowOnes & pre_q[k];
        end
    end

    // two independent channels
    tmr8_channel u_ch0 (
        .clk_sys(clk_sys),
        .rst(rst),
        .wr(wr0),
        .tapPulse(tapPulse),
        .subTick(subClkTick),
        .subSlowTick(subSlowTick),
        .prescalerTapSelect(prescalerTapSelect),
        .countInputPin(countInputPin0),
        .stat(stat0)
    );
    tmr8_channel u_ch1 (
        .clk_sys(clk_sys),
        .rst(rst),
        .wr(wr1),
        .tapPulse(tapPulse),
        .subTick(subClkTick),
        .subSlowTick(subSlowTick),
        .prescalerTapSelect(prescalerTapSelect),
        .countInputPin(countInputPin1),
        .stat(stat1)
    );
endmodule // tmr8_top

/* tb/tmr8_chk.sv */
// assertions on channel 0 of the dual timer
`timescale 1ns/1ps
module tmr8_chk (
    input wire logic clk_sys,
    input wire logic rst,
    input wire tmr8_pkg::tmr8_wr_t wr0,
    input wire logic countInputPin0,
    input wire tmr8_pkg::tmr8_stat_t stat0
);
    import tmr8_pkg::*;
    default clocking @(posedge clk_sys); endclocking
    default disable iff (rst);
    // running on a tick every clock, so counts are exact
    wire logic fast = stat0.ctl[CTL_RUN_BIT] && stat0.ctl[6:4] == 3'h6;
    wire logic [1:0] md = stat0.ctl[1:0];
    wire logic pin = stat0.dividerOutPin;
    // overflow then the interrupt a cycle later
    sequence s_wrap;
        stat0.count == CNT_MAX ##1 stat0.matchIrq;
    endsequence
    a_reset_pins: assert property ($fell(rst) |-> pin && stat0.pwmOutPin) else $error("pin");
    a_irq_pulse: assert property (stat0.matchIrq |=> !stat0.matchIrq) else $error("irq");
    a_irq_clears: assert property (stat0.matchIrq |-> stat0.count == 8'h00) else $error("clr");
    a_div_toggle: assert property (
        md == TMR8_DIVIDER && stat0.matchIrq |-> pin != $past(pin)) else $error("div");
    a_pwm_wrap: assert property (
        fast && md == TMR8_PWM && stat0.count == CNT_MAX && !wr0.ctlWr |-> s_wrap)
        else $error("wrap");
    a_pwm_match: assert property (
        fast && md == TMR8_PWM && !wr0.ctlWr && stat0.count != CNT_MAX
        && stat0.count == stat0.dutyRd |=> pin != $past(pin)
        && stat0.count == $past(stat0.count) + 8'h01) else $error("pwm");
    a_div_count: assert property (
        fast && md == TMR8_DIVIDER && !wr0.ctlWr
        && stat0.count != stat0.cmp |=> stat0.count == $past(stat0.count) + 8'h01)
        else $error("cnt");
    a_event_count: assert property (
        stat0.ctl[CTL_RUN_BIT] && md == TMR8_EVENT && !wr0.ctlWr
        && $past(countInputPin0) && !countInputPin0 && stat0.count != stat0.cmp
        |=> stat0.count == $past(stat0.count) + 8'h01) else $error("evt");
    a_stop_holds: assert property (
        !stat0.ctl[CTL_RUN_BIT] && !wr0.ctlWr |=> $stable(pin)) else $error("hold");
    a_ff_preset: assert property (
        !stat0.ctl[CTL_RUN_BIT] && wr0.ctlWr && !wr0.data[CTL_RUN_BIT]
        |=> pin == !$past(wr0.data[CTL_FF_BIT])) else $error("ff");
endmodule // tmr8_chk
bind tmr8_top tmr8_chk u_chk (.clk_sys(clk_sys), .rst(rst), .wr0(wr0),
    .countInputPin0(countInputPin0), .stat0(stat0));

/* tb/tmr8_pulse_src.sv */
// external count pulse source for the timer count pins
`timescale 1ns/1ps
module tmr8_pulse_src (
    input wire logic clk_sys,
    input wire logic start,
    input wire logic [7:0] pulses,
    input wire logic [3:0] hold,
    output logic countPin,
    output logic busy
);
    // idle high like a pulled-up line
    initial countPin = 1'b1;
    initial busy = 1'b0;
    // hold of two or more keeps each level legal; larger is a slow source
    always begin
        @(posedge clk_sys iff start);
        busy = 1'b1;
        repeat (pulses) begin
            #1 countPin = 1'b0;
            repeat (hold) @(posedge clk_sys);
            #1 countPin = 1'b1;
            repeat (hold) @(posedge clk_sys);
        end
        busy = 1'b0;
    end
endmodule // tmr8_pulse_src

/* tb/tmr8_bench.sv */
// self-checking bench for the dual timer
`timescale 1ns/1ps
module tmr8_bench;
    import tmr8_pkg::*;
    logic clk_sys = 1'b0;
    logic rst = 1'b1;
    tmr8_wr_t wr0 = '0;
    tmr8_wr_t wr1 = '0;
    logic start = 1'b0;
    logic cntPin, busy, p;
    tmr8_stat_t stat0, stat1;
    int n_errors = 0;
    int check_count = 0;
    int irqCount = 0;
    int n;
    // rows: stopped control, compare or duty, expected low time of the pin
    // divider rows also use the half and eighth taps, where low time is ticks times tap period
    logic [7:0] rowCtl [8] = '{8'h61, 8'h61, 8'h61, 8'h51, 8'h31, 8'h63, 8'h63, 8'h63};
    logic [7:0] rowVal [8] = '{8'h01, 8'h02, 8'hFF, 8'h01, 8'h01, 8'h02, 8'h80, 8'hFE};
    logic [8:0] rowLow [8] = '{9'h002, 9'h003, 9'h100, 9'h004, 9'h010, 9'h0FD, 9'h07F, 9'h001};
    always #50 clk_sys = ~clk_sys;
    // irq sampled mid-cycle, away from the edge that launches it
    always @(negedge clk_sys) if (stat0.matchIrq === 1'b1) irqCount++;
    // both count pins share one source; subclock and tap select left idle
    // output port latches taken as already set, so the pins are watched directly
    tmr8_top u_tmr8_top (.clk_sys(clk_sys), .rst(rst), .wr0(wr0), .wr1(wr1),
        .subClkTick(1'b0), .prescalerTapSelect(1'b0), .countInputPin0(cntPin),
        .countInputPin1(cntPin), .stat0(stat0), .stat1(stat1));
    tmr8_pulse_src u_tmr8_pulse_src (.clk_sys(clk_sys), .start(start), .pulses(8'h05),
        .hold(4'h2), .countPin(cntPin), .busy(busy));
    task automatic chk(input string nm, input logic [8:0] got, input logic [8:0] exp);
        check_count++;
        if (got !== exp) begin
            n_errors++;
            $display("mismatch %s expected %h seen %h", nm, exp, got);
        end
    endtask
    // advance k clocks, then let the edge settle
    task automatic tick(input int k);
        repeat (k) @(posedge clk_sys);
        #1;
    endtask
    // one-cycle strobe: sel 0 control, 1 compare, 2 duty
    task automatic wr(input bit ch, input int sel, input logic [7:0] d);
        tmr8_wr_t w;
        w = '{sel == 0, sel == 1, sel == 2, d};
        tick(1);
        if (ch) wr1 = w; else wr0 = w;
        tick(1);
        wr0 = '0;
        wr1 = '0;
    endtask
    task automatic finish_test;
        $display("checks %0d mismatches %0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    // tests need under two thousand cycles; ten thousand means a hang
    initial begin
        #1_000_000;
        n_errors++;
        finish_test;
    end
    initial begin
        tick(20);
        rst = 1'b0;
        tick(1);
        chk("pins", {stat0.dividerOutPin, stat1.pwmOutPin}, 9'h003);
        chk("ctl", stat1.ctl, 9'h000);
        $display("test reset done");
        foreach (rowCtl[i]) begin
            wr(0, 0, rowCtl[i]);
            wr(0, rowCtl[i][1] ? 2 : 1, rowVal[i]);
            wr(0, 0, rowCtl[i] | 8'h08);
            for (int j = 0; j < 600 && stat0.dividerOutPin !== 1'b0; j++) tick(1);
            for (n = 0; n < 600 && stat0.dividerOutPin === 1'b0; n++) tick(1);
            chk("low time", n[8:0], rowLow[i]);
            chk("pwm pin", stat0.pwmOutPin, 9'h001);
        end
        $display("test rows done");
        wr(0, 2, 8'h28);
        chk("duty held", stat0.dutyRd, 9'h0FE);
        for (int j = 0; j < 300 && stat0.matchIrq !== 1'b1; j++) tick(1);
        chk("duty moved", stat0.dutyRd, 9'h028);
        // level before the stopping write, which also carries a set init bit
        p = stat0.dividerOutPin;
        wr(0, 0, 8'hE3);
        tick(3);
        chk("held", stat0.dividerOutPin, p);
        wr(0, 0, 8'h83);
        chk("preset", stat0.pwmOutPin, 9'h000);
        wr(0, 0, 8'h03);
        chk("clear", stat0.pwmOutPin, 9'h001);
        wr(0, 2, 8'h32);
        chk("duty now", stat0.dutyRd, 9'h032);
        // running read shows the active stage, so the stopped write must already be there
        wr(0, 0, 8'h6B);
        chk("duty active", stat0.dutyRd, 9'h032);
        wr(0, 0, 8'h03);
        $display("test buffer done");
        wr(0, 1, 8'h03);
        wr(1, 1, 8'h10);
        wr(0, 0, 8'h08);
        wr(1, 0, 8'h08);
        n = irqCount;
        start = 1'b1;
        tick(1);
        start = 1'b0;
        for (int j = 0; j < 100 && busy !== 1'b0; j++) tick(1);
        tick(2);
        chk("irq", 9'(irqCount - n), 9'h001);
        chk("count0", stat0.count, 9'h001);
        chk("count1", stat1.count, 9'h005);
        $display("test event done");
        // stop, preset the pin low, then reset in mid-run
        wr(0, 0, 8'h01);
        wr(0, 0, 8'h81);
        chk("preset low", stat0.dividerOutPin, 9'h000);
        rst = 1'b1;
        tick(2);
        rst = 1'b0;
        tick(1);
        chk("reset pins", {stat0.dividerOutPin, stat1.pwmOutPin}, 9'h003);
        chk("reset ctl", stat0.ctl, 9'h000);
        chk("reset count", stat1.count, 9'h000);
        $display("test reset again done");
        finish_test;
    end
endmodule // tmr8_bench
